// ===== hdl/reset_seq_pkg.sv
// shared constants and types for the system reset sequencer
package reset_seq_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS     = 40;
  localparam int EXT_MIN_PULSE_NS  = 400;
  // least time, rounded up to whole cycles
  localparam int EXT_MIN_CYC       = (EXT_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TOUT_BASE_CYC_DEF = 1024;
  localparam int CNT_W             = 24;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [11:0] CAUSE_OFS = 12'h000;
  localparam logic [11:0] STATE_OFS = 12'h004;

  localparam int FLAG_TESTPORT = 4;
  localparam int FLAG_WATCHDOG = 3;
  localparam int FLAG_BROWNOUT = 2;
  localparam int FLAG_EXTERNAL = 1;
  localparam int FLAG_POWERON  = 0;

  localparam logic [4:0] FLAGS_RESET = 5'h00;

  // brown-out level fuse coding that switches detection off
  localparam logic [2:0] BOD_DISABLED = 3'h7;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'b0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic testport;
    logic watchdog;
    logic brownout;
    logic external;
    logic powerOn;
  } reset_cause_type;

  typedef struct packed {
    logic [1:0] startupTime;
    logic [3:0] clockSelect;
    logic [2:0] brownoutLevel;
  } fuse_type;

  typedef enum logic [1:0] {
    SEQ_HOLD,
    SEQ_COUNT,
    SEQ_RUN
  } seq_state_type;

endpackage

// ===== hdl/ext_pin_filter.sv
// pulse-width filter for the low-active external reset pin
`timescale 1ns/1ps
module ext_pin_filter #(
  parameter int MIN_CYC = 10
) (
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic pinLevel,
  output logic      lowValid_r
);

  logic [7:0] lowCnt_r;
  logic [7:0] lowCnt_nxt;
  logic       lowValid_nxt;

  if (MIN_CYC < 1 || MIN_CYC > 255)
  begin : g_chk
    $error("ext_pin_filter: MIN_CYC out of range");
  end

  always_comb
  begin
    lowCnt_nxt   = lowCnt_r;
    lowValid_nxt = lowValid_r;
    if (pinLevel)
    begin
      // rising edge ends the request at once
      lowCnt_nxt   = 8'h00;
      lowValid_nxt = 1'b0;
    end
    else if (lowCnt_r < 8'(MIN_CYC))
    begin
      lowCnt_nxt = lowCnt_r + 8'h01;
    end
    else
    begin
      lowValid_nxt = 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      lowCnt_r   <= 8'h00;
      lowValid_r <= 1'b0;
    end
    else
    begin
      lowCnt_r   <= lowCnt_nxt;
      lowValid_r <= lowValid_nxt;
    end
  end

endmodule

// ===== hdl/release_timer.sv
// loadable down-counter that stretches reset release
`timescale 1ns/1ps
module release_timer #(
  parameter int CNT_W = 24
) (
  input  wire logic             clock,
  input  wire logic             sys_rst,
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] length,
  output logic                  busy_r,
  output logic                  done_r
);

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic             busy_nxt;
  logic             done_nxt;

  if (CNT_W < 2 || CNT_W > 31)
  begin : g_chk
    $error("release_timer: CNT_W out of range");
  end

  always_comb
  begin
    cnt_nxt  = cnt_r;
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    if (load)
    begin
      cnt_nxt  = length;
      busy_nxt = 1'b1;
    end
    else if (busy_r)
    begin
      if (cnt_r <= {{(CNT_W-1){1'b0}}, 1'b1})
      begin
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
      end
      else
      begin
        cnt_nxt = cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      cnt_r  <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end
    else
    begin
      cnt_r  <= cnt_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
    end
  end

endmodule

// ===== hdl/system_reset_sequencer.sv
// reset source combiner, release delay and reset-cause register
`timescale 1ns/1ps
// Functional notes
// - five sources: power-on, pin, watchdog, brown-out, test port; any holds reset.
// - reset loads all I/O registers; release starts fetch at reset vector.
// - port pins return to initial state combinationally when a source is active.
// - after all sources drop, a delay counter stretches internal reset.
// - startup-time and clock-select fuses choose the delay length.
// - pin low longer than minimum width resets; shorter pulses may be ignored.
// - pin rising starts the delay counter; release after time-out.
// - watchdog expiry resets only while the watchdog is enabled.
// - supply-low resets only while brown-out detection is enabled.
// - reset held while the test-port reset bit is one.
// - supply rising past threshold starts the power-up delay counter.
// - supply falling below level reasserts reset immediately, no counting.
// - brown-out level fuse picks trip level; one coding disables detection.
// - brown-out resets at once; release after delay time-out on recovery.
// - watchdog gives a one-cycle pulse; its falling edge starts the counter.
// - cause flags: test port 4, watchdog 3, brown-out 2, pin 1, power-on 0.
// - power-on flag cleared only by writing zero; others also by power-on.
module system_reset_sequencer
  import reset_seq_pkg::*;
#(
  parameter int TOUT_BASE_CYC = reset_seq_pkg::TOUT_BASE_CYC_DEF,
  parameter int EXT_MIN_CYC   = reset_seq_pkg::EXT_MIN_CYC
) (
  input  wire logic                 clock,
  input  wire logic                 sys_rst,
  // supply detectors, pin, watchdog, test port
  input  wire logic                 supplyBelowPor,
  input  wire logic                 extResetPinLevel,
  input  wire logic                 watchdogExpire,
  input  wire logic                 watchdogEnable,
  input  wire logic                 supplyBelowBot,
  input  wire logic                 testportResetBit,
  input  wire reset_seq_pkg::fuse_type fuses,
  // outputs to the rest of the chip
  output logic                      internalReset_r,
  output logic                      ioPortReset,
  output logic                      vectorFetch_r,
  output logic                      brownoutDetectorEn_r,
  output logic [2:0]                brownoutTripLevel_r,
  // AHB-Lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic [31:0]               hrdata
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (TOUT_BASE_CYC < 1 || (TOUT_BASE_CYC << 4) >= (1 << CNT_W))
  begin : g_chk_tout
    $error("system_reset_sequencer: TOUT_BASE_CYC out of range");
  end

  // ----------------------------------------------------------------
  // source conditioning
  // ----------------------------------------------------------------
  logic            extLow;
  logic            wdPulse_r;
  logic            wdPulse_nxt;
  reset_cause_type srcNow;
  logic            anySrc;
  logic            bodEnable;

  // pin needs a minimum low width before it counts
  ext_pin_filter #(
    .MIN_CYC    (EXT_MIN_CYC)
  ) u_ext_filter (
    .clock      (clock),
    .sys_rst    (sys_rst),
    .pinLevel   (extResetPinLevel),
    .lowValid_r (extLow)
  );

  always_comb
  begin
    wdPulse_nxt = watchdogExpire & watchdogEnable & ~wdPulse_r;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      wdPulse_r <= 1'b0;
    end
    else
    begin
      wdPulse_r <= wdPulse_nxt;
    end
  end

  always_comb
  begin
    bodEnable       = (fuses.brownoutLevel != BOD_DISABLED);
    srcNow.powerOn  = supplyBelowPor;
    srcNow.external = extLow;
    srcNow.watchdog = wdPulse_r;
    srcNow.brownout = supplyBelowBot & bodEnable;
    srcNow.testport = testportResetBit;
    anySrc          = |srcNow;
  end

  // ports must fall back without waiting for a clock edge
  assign ioPortReset = anySrc | internalReset_r;

  // ----------------------------------------------------------------
  // delay length from fuses
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] toutLen;
  logic [2:0]       toutShift;

  always_comb
  begin
    toutShift = {1'b0, fuses.startupTime} + {2'b00, fuses.clockSelect[0]};
    toutLen   = CNT_W'(TOUT_BASE_CYC) << toutShift;
  end

  // ----------------------------------------------------------------
  // release sequencer
  // ----------------------------------------------------------------
  seq_state_type state_r;
  seq_state_type state_nxt;
  logic          timerLoad;
  logic          timerBusy;
  logic          timerDone;
  logic          internalReset_nxt;
  logic          vectorFetch_nxt;

  release_timer #(
    .CNT_W   (CNT_W)
  ) u_timer (
    .clock   (clock),
    .sys_rst (sys_rst),
    .load    (timerLoad),
    .length  (toutLen),
    .busy_r  (timerBusy),
    .done_r  (timerDone)
  );

  always_comb
  begin
    state_nxt         = state_r;
    timerLoad         = 1'b0;
    internalReset_nxt = 1'b1;
    vectorFetch_nxt   = 1'b0;
    case (state_r)
      SEQ_HOLD:
      begin
        if (!anySrc)
        begin
          // last source gone: pin rise, supply up, pulse end
          timerLoad = 1'b1;
          state_nxt = SEQ_COUNT;
        end
      end
      SEQ_COUNT:
      begin
        if (anySrc)
        begin
          state_nxt = SEQ_HOLD;
        end
        else if (timerDone)
        begin
          state_nxt         = SEQ_RUN;
          internalReset_nxt = 1'b0;
          vectorFetch_nxt   = 1'b1;
        end
      end
      SEQ_RUN:
      begin
        internalReset_nxt = 1'b0;
        if (anySrc)
        begin
          // no counting on the way in
          state_nxt         = SEQ_HOLD;
          internalReset_nxt = 1'b1;
        end
      end
      default:
      begin
        state_nxt = SEQ_HOLD;
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      state_r         <= SEQ_HOLD;
      internalReset_r <= 1'b1;
      vectorFetch_r   <= 1'b0;
    end
    else
    begin
      state_r         <= state_nxt;
      internalReset_r <= internalReset_nxt;
      vectorFetch_r   <= vectorFetch_nxt;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      brownoutDetectorEn_r <= 1'b0;
      brownoutTripLevel_r  <= 3'h0;
    end
    else
    begin
      brownoutDetectorEn_r <= bodEnable;
      brownoutTripLevel_r  <= fuses.brownoutLevel;
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  logic        wrPend_r;
  logic        wrPend_nxt;
  logic [11:0] wrAddr_r;
  logic [11:0] wrAddr_nxt;
  logic        addrPhase;
  logic [31:0] hrdata_nxt;
  logic        wrCause;

  always_comb
  begin
    addrPhase  = hsel & hready & (htrans == HTRANS_NONSEQ);
    wrPend_nxt = addrPhase & hwrite;
    wrAddr_nxt = addrPhase ? haddr[11:0] : wrAddr_r;
    wrCause    = wrPend_r & (wrAddr_r == CAUSE_OFS);
  end

  // ----------------------------------------------------------------
  // reset-cause flags
  // ----------------------------------------------------------------
  reset_cause_type flags_r;
  reset_cause_type flags_nxt;

  always_comb
  begin
    flags_nxt = flags_r;
    // zero bits clear, ones leave the flag alone
    if (wrCause)
    begin
      flags_nxt = flags_r & reset_cause_type'(hwdata[4:0]);
    end
    // power-on wipes the other causes
    if (srcNow.powerOn)
    begin
      flags_nxt.testport = 1'b0;
      flags_nxt.watchdog = 1'b0;
      flags_nxt.brownout = 1'b0;
      flags_nxt.external = 1'b0;
    end
    // a cause arriving with a clear still lands
    flags_nxt = flags_nxt | srcNow;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      flags_r <= reset_cause_type'(FLAGS_RESET);
    end
    else
    begin
      flags_r <= flags_nxt;
    end
  end

  // ----------------------------------------------------------------
  // read data and response
  // ----------------------------------------------------------------
  // read mux uses next flag value so a write just before is seen
  always_comb
  begin
    hrdata_nxt = hrdata;
    if (addrPhase && !hwrite)
    begin
      case (haddr[11:0])
        CAUSE_OFS:
        begin
          hrdata_nxt = {27'h0000000, flags_nxt};
        end
        STATE_OFS:
        begin
          hrdata_nxt = {16'h0000, 3'h0, srcNow, 2'h0, timerBusy,
                        internalReset_r, 2'h0, state_r};
        end
        default:
        begin
          hrdata_nxt = 32'h00000000;
        end
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      wrPend_r  <= 1'b0;
      wrAddr_r  <= 12'h000;
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b0;
      hresp     <= HRESP_OKAY;
    end
    else
    begin
      wrPend_r  <= wrPend_nxt;
      wrAddr_r  <= wrAddr_nxt;
      hrdata    <= hrdata_nxt;
      // zero wait states; always OKAY
      hreadyout <= 1'b1;
      hresp     <= HRESP_OKAY;
    end
  end

endmodule

// ===== tb/supply_model.sv
// pin driver and supply detector model
`timescale 1ns/1ps
module supply_model (
  input  wire logic clock,
  input  wire logic porLow,
  input  wire logic pinLow,
  input  wire logic botLow,
  output logic      supplyBelowPor,
  output logic      extResetPinLevel,
  output logic      supplyBelowBot
);
  initial supplyBelowPor = 1'b1;
  initial extResetPinLevel = 1'b1;
  initial supplyBelowBot = 1'b0;
  // released pin floats to its pull-up level
  always @(posedge clock)
  begin
    supplyBelowPor <= porLow;
    extResetPinLevel <= !pinLow;
    supplyBelowBot <= botLow;
  end
endmodule

// ===== tb/system_reset_sequencer_chk.sv
// port checker for the system reset sequencer
`timescale 1ns/1ps
module system_reset_sequencer_chk
  import reset_seq_pkg::*;
#(
  parameter int EXT_MIN_CYC = 10
) (
  input wire logic                     clock,
  input wire logic                     sys_rst,
  input wire logic                     supplyBelowPor,
  input wire logic                     extResetPinLevel,
  input wire logic                     watchdogExpire,
  input wire logic                     watchdogEnable,
  input wire logic                     supplyBelowBot,
  input wire logic                     testportResetBit,
  input wire reset_seq_pkg::fuse_type  fuses,
  input wire logic                     internalReset_r,
  input wire logic                     ioPortReset,
  input wire logic                     vectorFetch_r,
  input wire logic                     brownoutDetectorEn_r
);
  logic [7:0] lowCnt_r;
  logic [7:0] lowCnt_nxt;
  // saturate so a long hold does not wrap
  always_comb lowCnt_nxt = extResetPinLevel ? 8'h00 : lowCnt_r + {7'h0, lowCnt_r != 8'hff};
  always_ff @(posedge clock) lowCnt_r <= sys_rst ? 8'h00 : lowCnt_nxt;
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  port_force_a: assert property (testportResetBit || supplyBelowPor |-> ioPortReset)
    else $error("port reset not forced");
  tp_hold_a: assert property (testportResetBit |=> internalReset_r)
    else $error("test port reset not held");
  por_at_once_a: assert property (supplyBelowPor |=> internalReset_r)
    else $error("power-on reset late");
  wdog_pulse_a: assert property (watchdogExpire && watchdogEnable
    && !$past(watchdogExpire) |-> ##[1:3] internalReset_r)
    else $error("watchdog reset missing");
  bod_reset_a: assert property (supplyBelowBot && brownoutDetectorEn_r |=> internalReset_r)
    else $error("brown-out reset missing");
  vec_pulse_a: assert property ($fell(internalReset_r) |-> vectorFetch_r ##1 !vectorFetch_r)
    else $error("vector fetch pulse wrong");
  stretch_a: assert property ($fell(internalReset_r)
    |-> !$past(testportResetBit, 4) && !$past(supplyBelowPor, 4))
    else $error("release not stretched");
  bod_fuse_a: assert property (!$past(sys_rst)
    |-> brownoutDetectorEn_r == ($past(fuses.brownoutLevel) != BOD_DISABLED))
    else $error("brown-out enable wrong");
  pin_low_a: assert property (lowCnt_r > EXT_MIN_CYC + 3 |-> internalReset_r)
    else $error("pin reset missing");
  cover property ($fell(internalReset_r));
  cover property (lowCnt_r == 8'h05 ##1 extResetPinLevel);
  cover property (watchdogExpire && watchdogEnable);
endmodule
bind system_reset_sequencer system_reset_sequencer_chk #(.EXT_MIN_CYC(EXT_MIN_CYC)) chk (
  .clock(clock), .sys_rst(sys_rst), .supplyBelowPor(supplyBelowPor),
  .extResetPinLevel(extResetPinLevel), .watchdogExpire(watchdogExpire),
  .watchdogEnable(watchdogEnable), .supplyBelowBot(supplyBelowBot),
  .testportResetBit(testportResetBit), .fuses(fuses), .internalReset_r(internalReset_r),
  .ioPortReset(ioPortReset), .vectorFetch_r(vectorFetch_r),
  .brownoutDetectorEn_r(brownoutDetectorEn_r));

// ===== tb/system_reset_sequencer_bench.sv
// self-checking bench for the system reset sequencer
`timescale 1ns/1ps
module system_reset_sequencer_bench;
  import reset_seq_pkg::*;
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic        porLow = 1'b1;
  logic        pinLow = 1'b0;
  logic        botLow = 1'b0;
  logic        wdExp = 1'b0;
  logic        wdEn = 1'b0;
  logic        tpBit = 1'b0;
  fuse_type    fz = 9'h007;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [2:0]  trip;
  logic        supPor, pinLvl, supBot, intRst, ioRst, vecF, bodEn, hrdy, hresp;
  int          failures = 0;
  int          comparisons = 0;
  int          n0, n1;
  always #20 clock = ~clock;
  supply_model PM (.clock(clock), .porLow(porLow), .pinLow(pinLow), .botLow(botLow),
    .supplyBelowPor(supPor), .extResetPinLevel(pinLvl), .supplyBelowBot(supBot));
  // short release count keeps the run brief
  system_reset_sequencer #(.TOUT_BASE_CYC(4), .EXT_MIN_CYC(10)) DUT (
    .clock(clock), .sys_rst(sys_rst), .supplyBelowPor(supPor), .extResetPinLevel(pinLvl),
    .watchdogExpire(wdExp), .watchdogEnable(wdEn), .supplyBelowBot(supBot),
    .testportResetBit(tpBit), .fuses(fz), .internalReset_r(intRst), .ioPortReset(ioRst),
    .vectorFetch_r(vecF), .brownoutDetectorEn_r(bodEn), .brownoutTripLevel_r(trip),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy), .hresp(hresp), .hrdata(hrdata));
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task wrdy;
    int k;
    k = 0;
    @(posedge clock);
    while (hrdy !== 1'b1 && k < 50)
    begin
      @(posedge clock);
      k++;
    end
  endtask
  task ahb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {20'h0, a};
    wrdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    wrdy();
    rd = hrdata;
    chk("hresp", hresp, HRESP_OKAY);
  endtask
  task cause(input logic [4:0] e);
    ahb(1'b0, CAUSE_OFS, 32'h0);
    chk("cause flags", rd, {27'h0, e});
  endtask
  task rel(output int n);
    n = 0;
    while (intRst !== 1'b0 && n < 300)
    begin
      @(posedge clock);
      n++;
    end
    chk("released", intRst, 1'b0);
    chk("vector fetch", vecF, 1'b1);
  endtask
  task seen(output int n);
    n = 0;
    while (intRst !== 1'b1 && n < 20)
    begin
      @(posedge clock);
      n++;
    end
    chk("asserted", intRst, 1'b1);
  endtask
  task pulse_tp(output int n);
    @(posedge clock);
    tpBit <= 1'b1;
    #1 chk("port reset", ioRst, 1'b1);
    repeat (3) @(posedge clock);
    chk("held", intRst, 1'b1);
    tpBit <= 1'b0;
    rel(n);
  endtask
  task t_power;
    @(posedge clock);
    porLow <= 1'b0;
    rel(n0);
    chk("por stretch", n0 >= 4, 1'b1);
    chk("port free", ioRst, 1'b0);
    ahb(1'b0, STATE_OFS, 32'h0);
    chk("state run", rd, 32'h00000002);
    cause(5'h01);
    ahb(1'b1, CAUSE_OFS, 32'h0);
    cause(5'h00);
    ahb(1'b0, 12'h0f0, 32'h0);
    chk("unmapped", rd, 32'h0);
  endtask
  task t_length;
    pulse_tp(n0);
    cause(5'h10);
    fz.startupTime <= 2'h1;
    pulse_tp(n1);
    chk("len x2", n1 - n0, 4);
    fz.clockSelect <= 4'h1;
    pulse_tp(n1);
    chk("len x4", n1 - n0, 12);
    fz <= 9'h007;
    ahb(1'b1, CAUSE_OFS, 32'h0);
  endtask
  task t_pin;
    pinLow <= 1'b1;
    repeat (5) @(posedge clock);
    pinLow <= 1'b0;
    repeat (20) @(posedge clock);
    chk("short pin", intRst, 1'b0);
    pinLow <= 1'b1;
    repeat (20) @(posedge clock);
    chk("long pin", intRst, 1'b1);
    pinLow <= 1'b0;
    rel(n0);
    chk("pin stretch", n0 >= 4, 1'b1);
    cause(5'h02);
    ahb(1'b1, CAUSE_OFS, 32'h0);
  endtask
  task t_wdog;
    wdExp <= 1'b1;
    @(posedge clock);
    wdExp <= 1'b0;
    repeat (5) @(posedge clock);
    chk("wdog off", intRst, 1'b0);
    wdEn <= 1'b1;
    wdExp <= 1'b1;
    @(posedge clock);
    wdExp <= 1'b0;
    seen(n0);
    rel(n1);
    chk("wdog stretch", n1 >= 4, 1'b1);
    cause(5'h08);
    ahb(1'b1, CAUSE_OFS, 32'h0);
  endtask
  task t_bod;
    botLow <= 1'b1;
    repeat (6) @(posedge clock);
    chk("bod off", intRst, 1'b0);
    botLow <= 1'b0;
    fz.brownoutLevel <= 3'h3;
    repeat (3) @(posedge clock);
    chk("bod on", bodEn, 1'b1);
    chk("trip", trip, 3'h3);
    botLow <= 1'b1;
    seen(n0);
    chk("bod at once", n0 <= 3, 1'b1);
    botLow <= 1'b0;
    rel(n1);
    chk("bod stretch", n1 >= 4, 1'b1);
    cause(5'h04);
  endtask
  task t_por_flags;
    pulse_tp(n0);
    porLow <= 1'b1;
    repeat (3) @(posedge clock);
    porLow <= 1'b0;
    rel(n0);
    cause(5'h01);
    ahb(1'b1, CAUSE_OFS, 32'h1f);
    cause(5'h01);
  endtask
  task close_out;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    t_power();
    t_length();
    t_pin();
    t_wdog();
    t_bod();
    t_por_flags();
    close_out();
  end
  // whole sequence needs a few hundred cycles
  initial
  begin
    repeat (20000) @(posedge clock);
    failures++;
    close_out();
  end
endmodule
